// ---- charger_regs_pkg.sv ----
// Shared constants and carrier types of the charger mask and charge bank
package charger_regs_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets on the internal register port
  localparam logic [7:0] OFF_CONV_FLAG   = 8'h05; // Converter event flags
  localparam logic [7:0] OFF_FAULT_FLAG  = 8'h06; // Fault/timer flags
  localparam logic [7:0] OFF_CONV_MASK   = 8'h09; // Converter masks
  localparam logic [7:0] OFF_FAULT_MASK  = 8'h0a; // Fault/timer masks
  localparam logic [7:0] OFF_VREG        = 8'h12; // Regulation voltage
  localparam logic [7:0] OFF_FAST_CHG    = 8'h13; // Fast-charge current
  localparam logic [7:0] OFF_PRECHG      = 8'h14; // Pre-charge and range
  localparam logic [7:0] OFF_TERM        = 8'h15; // Termination control

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_CONV_MASK   = 8'h71;
  localparam logic [7:0] RST_FAULT_MASK  = 8'h00;
  localparam logic [6:0] RST_VREG_CODE   = 7'h3c;
  localparam logic [7:0] RST_FAST_CHG    = 8'h08;
  localparam logic [7:0] RST_PRECHG      = 8'h02;
  localparam logic [7:0] RST_TERM        = 8'h14;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int POS_STEP_SEL   = 7; // Pre-charge reg: step select
  localparam int POS_PRE_LO     = 0; // Pre-charge code low bit
  localparam int POS_TERM_LO    = 1; // Termination code low bit
  localparam int POS_TERM_DIS   = 0; // Termination disable bit

  // Event bits that really exist; reserved positions never latch
  localparam logic [7:0] CONV_LIVE_BITS  = 8'hf1;
  localparam logic [7:0] FAULT_LIVE_BITS = 8'h7f;

  ////////////////////////////////////////////////////////////////////////
  // Regulation voltage scale, in millivolts
  localparam int VREG_BASE_MV = 3600;
  localparam int VREG_STEP_MV = 10;
  localparam int VREG_MAX_MV  = 4600;
  localparam logic [6:0] VREG_MAX_CODE =
    7'((VREG_MAX_MV - VREG_BASE_MV) / VREG_STEP_MV);

  ////////////////////////////////////////////////////////////////////////
  // Register access request from the serial bus engine
  typedef struct packed {
    logic       wr;    // One-cycle write strobe
    logic       rd;    // One-cycle read strobe
    logic [7:0] addr;  // Register offset
    logic [7:0] wdata; // Write data
  } reg_req_t;

  // Stored charge settings handed to the charge loop
  typedef struct packed {
    logic       term_disable;               // 1 = no termination
    logic [4:0] termination_percent_code;   // Percent of fast charge
    logic       charge_step_select;         // 0 = 1.25 mA, 1 = 2.5 mA
    logic [4:0] precharge_code;             // Pre-charge steps
    logic [7:0] fast_charge_code;           // Fast-charge steps
    logic [6:0] regulation_voltage_target;  // 10 mV above 3.6 V
  } charge_cfg_t;

endpackage : charger_regs_pkg

// ---- event_flag_bank.sv ----
// Latched event flags, cleared by a read, gated by a mask
`timescale 1ns/1ps
module event_flag_bank #(
  parameter int         W    = 8,        // Flags in the bank
  parameter logic [7:0] LIVE = 8'hff     // Positions that may latch
) (
  input  wire logic         clk,         // System clock
  input  wire logic         rstn,        // Async reset, active low
  input  wire logic [W-1:0] event_i,     // One-cycle event pulses
  input  wire logic         clear_i,     // Read of the flag register
  input  wire logic [W-1:0] mask_i,      // 1 = keep off interrupt
  output logic      [W-1:0] flags_o,     // Latched flags
  output logic              pending_o    // Any unmasked flag set
);

  logic [W-1:0] flags_reg;   // Sticky flags
  logic [W-1:0] flags_next;  // Next value
  logic [W-1:0] live;        // Usable positions

  assign live = LIVE[W-1:0];

  // A set in the clearing cycle wins, so no event is lost
  assign flags_next = (flags_reg & ~{W{clear_i}}) | (event_i & live);

  // Masked flags still latch; only the interrupt term drops them
  assign pending_o = |(flags_reg & ~mask_i);

  assign flags_o = flags_reg;

  // Flag storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

endmodule : event_flag_bank

// ---- regulation_clamp.sv ----
// Saturates a written regulation code at the highest legal target
`timescale 1ns/1ps
module regulation_clamp #(
  parameter logic [6:0] MAX_CODE = 7'h64  // Highest legal code
) (
  input  wire logic [6:0] code_i,         // Code as written
  output logic      [6:0] code_o          // Code as stored
);

  // Larger codes would ask for an overvoltage; keep the ceiling
  assign code_o = (code_i > MAX_CODE) ? MAX_CODE : code_i;

endmodule : regulation_clamp

// ---- charger_mask_and_charge_regs.sv ----
// Interrupt mask, event flag and charge setting registers of the charger
`timescale 1ns/1ps
module charger_mask_and_charge_regs (
  input  wire logic                           SYS_CLK,     // 40 MHz
  input  wire logic                           RSTN,        // Async, low
  input  wire charger_regs_pkg::reg_req_t     REG_REQ,     // Access
  output logic [7:0]                          REG_RDATA,   // Read data
  output logic                                REG_RVALID,  // Data valid
  input  wire logic [7:0]                     CONV_EVENTS, // Conv pulses
  input  wire logic [7:0]                     FAULT_EVENTS,// Fault pulses
  output logic                                INT_N,       // Interrupt
  output charger_regs_pkg::charge_cfg_t       CHARGE_CFG,  // Settings
  output logic [8:0]                          FAST_UNITS,  // 1.25 mA units
  output logic [5:0]                          PRE_UNITS,   // 1.25 mA units
  output logic                                TERM_ENABLE  // Term active
);

  import charger_regs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Address decode

  // One-cycle strobes from the bus engine inside the device,
  // so no wait state is ever needed
  logic hit_conv_flag;   // Converter flag register selected
  logic hit_fault_flag;  // Fault flag register selected
  logic hit_conv_mask;   // Converter mask register selected
  logic hit_fault_mask;  // Fault mask register selected
  logic hit_vreg;        // Regulation register selected
  logic hit_fast;        // Fast-charge register selected
  logic hit_pre;         // Pre-charge register selected
  logic hit_term;        // Termination register selected
  logic hit_any;         // Any mapped offset

  assign hit_conv_flag  = (REG_REQ.addr == OFF_CONV_FLAG);
  assign hit_fault_flag = (REG_REQ.addr == OFF_FAULT_FLAG);
  assign hit_conv_mask  = (REG_REQ.addr == OFF_CONV_MASK);
  assign hit_fault_mask = (REG_REQ.addr == OFF_FAULT_MASK);
  assign hit_vreg       = (REG_REQ.addr == OFF_VREG);
  assign hit_fast       = (REG_REQ.addr == OFF_FAST_CHG);
  assign hit_pre        = (REG_REQ.addr == OFF_PRECHG);
  assign hit_term       = (REG_REQ.addr == OFF_TERM);

  // Unmapped offsets still answer a read
  assign hit_any        = hit_conv_flag | hit_fault_flag | hit_conv_mask
                        | hit_fault_mask | hit_vreg | hit_fast | hit_pre
                        | hit_term;

  // Write strobes; flag registers take no writes
  // A read beside a write sees the old byte
  logic wr_conv_mask;    // Write converter masks
  logic wr_fault_mask;   // Write fault masks
  logic wr_vreg;         // Write regulation code
  logic wr_fast;         // Write fast-charge code
  logic wr_pre;          // Write pre-charge register
  logic wr_term;         // Write termination register

  assign wr_conv_mask  = REG_REQ.wr & hit_conv_mask;
  assign wr_fault_mask = REG_REQ.wr & hit_fault_mask;
  assign wr_vreg       = REG_REQ.wr & hit_vreg;
  assign wr_fast       = REG_REQ.wr & hit_fast;
  assign wr_pre        = REG_REQ.wr & hit_pre;
  assign wr_term       = REG_REQ.wr & hit_term;

  // Read strobes that clear the flag banks
  // Only reads clear flags
  logic rd_conv_flag;    // Read of converter flags
  logic rd_fault_flag;   // Read of fault flags

  assign rd_conv_flag  = REG_REQ.rd & hit_conv_flag;
  assign rd_fault_flag = REG_REQ.rd & hit_fault_flag;

  //////////////////////////////////////////////////////////////////////////
  // Mask registers

  // Masks gate the interrupt, not the latch,
  // so software can still poll a masked event
  logic [7:0] conv_mask_reg;    // Converter/comparator masks
  logic [7:0] conv_mask_next;   // Next value
  logic [7:0] fault_mask_reg;   // Fault/timer masks
  logic [7:0] fault_mask_next;  // Next value

  // All eight bits are storage, reserved ones included
  // No bit is forced, so read-back matches
  assign conv_mask_next  = wr_conv_mask ? REG_REQ.wdata
                                        : conv_mask_reg;
  assign fault_mask_next = wr_fault_mask ? REG_REQ.wdata
                                         : fault_mask_reg;

  // Reset leaves converter-ready unmasked, comparators and thermistor
  // masked, and every fault and timer event unmasked
  // Reserved mask bits reset to zero
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      conv_mask_reg  <= RST_CONV_MASK;
      fault_mask_reg <= RST_FAULT_MASK;
    end else begin
      conv_mask_reg  <= conv_mask_next;
      fault_mask_reg <= fault_mask_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Charge setting registers

  // The charge loop lags a write by one cycle;
  // the register port reads the new byte at once
  logic [6:0] vreg_reg;         // Stored regulation code
  logic [6:0] vreg_next;        // Next value
  logic [6:0] vreg_clamped;     // Written code after saturation
  logic [7:0] fast_reg;         // Fast-charge code
  logic [7:0] fast_next;        // Next value
  logic [7:0] pre_reg;          // Pre-charge register, whole byte
  logic [7:0] pre_next;         // Next value
  logic [7:0] term_reg;         // Termination register, whole byte
  logic [7:0] term_next;        // Next value

  // Saturation happens on the way in, so reads see the stored code
  // Bit 7 is reserved and reads as zero
  regulation_clamp #(
    .MAX_CODE (VREG_MAX_CODE)
  ) u_vreg_clamp (
    .code_i   (REG_REQ.wdata[6:0]),
    .code_o   (vreg_clamped)
  );

  // Too large a code is stored as the ceiling
  assign vreg_next = wr_vreg ? vreg_clamped : vreg_reg;
  assign fast_next = wr_fast ? REG_REQ.wdata : fast_reg;
  // Reserved pre-charge bits are stored
  assign pre_next  = wr_pre  ? REG_REQ.wdata : pre_reg;
  // A zero termination code is stored as written; it is not repaired
  assign term_next = wr_term ? REG_REQ.wdata : term_reg;

  // Setting storage with its power-on values
  // Reset codes come from the package
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      vreg_reg <= RST_VREG_CODE;
      fast_reg <= RST_FAST_CHG;
      pre_reg  <= RST_PRECHG;
      term_reg <= RST_TERM;
    end else begin
      vreg_reg <= vreg_next;
      fast_reg <= fast_next;
      pre_reg  <= pre_next;
      term_reg <= term_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event flags and interrupt

  // New events beat the read clear,
  // so an event in a read cycle survives
  logic [7:0] conv_flags;       // Converter/comparator flags
  logic [7:0] fault_flags;      // Fault/timer flags
  logic       conv_pending;     // Unmasked converter flag set
  logic       fault_pending;    // Unmasked fault flag set

  // Converter-ready, comparator alarms, open thermistor
  // Bits 3..1 are reserved, never latch
  event_flag_bank #(
    .W         (8),
    .LIVE      (CONV_LIVE_BITS)
  ) u_conv_flags (
    .clk       (SYS_CLK),
    .rstn      (RSTN),
    .event_i   (CONV_EVENTS),
    .clear_i   (rd_conv_flag),
    .mask_i    (conv_mask_reg),
    .flags_o   (conv_flags),
    .pending_o (conv_pending)
  );

  // Watchdog, safety timer, overcurrent, pin open, button timers
  // Bit 7 is reserved, never latches
  event_flag_bank #(
    .W         (8),
    .LIVE      (FAULT_LIVE_BITS)
  ) u_fault_flags (
    .clk       (SYS_CLK),
    .rstn      (RSTN),
    .event_i   (FAULT_EVENTS),
    .clear_i   (rd_fault_flag),
    .mask_i    (fault_mask_reg),
    .flags_o   (fault_flags),
    .pending_o (fault_pending)
  );

  // Idle high, so reset shows no interrupt
  logic int_n_reg;    // Registered interrupt, active low
  logic int_n_next;   // Next value

  // A mask write shows two cycles later,
  // and an event one cycle after its latch
  // Low while any flag whose mask bit is zero remains set
  assign int_n_next = ~(conv_pending | fault_pending);

  // Registered so the pin never glitches on decode paths
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      int_n_reg <= 1'b1;
    end else begin
      int_n_reg <= int_n_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path

  // Fixed one-cycle latency, no waiting,
  // and the data byte holds until the next read
  logic [7:0] rd_mux;       // Selected register contents
  logic [7:0] rdata_reg;    // Held read data
  logic [7:0] rdata_next;   // Next value
  logic       rvalid_reg;   // One-cycle read answer
  logic       hold_rdata;   // Keep data between reads

  // Selects are one-hot, so OR them
  // Unmapped offsets read as zero; reserved bits read as stored, except regulation bit 7, which reads as zero
  assign rd_mux =
      ({8{hit_conv_flag}}  & conv_flags)
    | ({8{hit_fault_flag}} & fault_flags)
    | ({8{hit_conv_mask}}  & conv_mask_reg)
    | ({8{hit_fault_mask}} & fault_mask_reg)
    | ({8{hit_vreg}}       & {1'b0, vreg_reg})
    | ({8{hit_fast}}       & fast_reg)
    | ({8{hit_pre}}        & pre_reg)
    | ({8{hit_term}}       & term_reg);

  // Flags are sampled before the clear lands, so a read sees them
  // A write alone leaves the read data
  assign hold_rdata = ~REG_REQ.rd;
  assign rdata_next = hold_rdata ? rdata_reg
                                 : (hit_any ? rd_mux : 8'h00);

  // Answer one cycle after the read strobe
  // Valid pulses; data holds
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= REG_REQ.rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Settings to the charge loop
  // Registered to hide decode glitches

  charge_cfg_t cfg_next;    // Settings gathered from storage
  charge_cfg_t cfg_reg;     // Registered copy for the outputs
  logic [8:0]  fast_units;  // Fast-charge current, 1.25 mA units
  logic [5:0]  pre_units;   // Pre-charge current, 1.25 mA units
  logic [8:0]  fast_units_reg;
  logic [5:0]  pre_units_reg;
  logic        term_enable_reg;   // Termination active, registered
  logic        term_enable_next;  // Next value
  logic        step_sel;    // Range bit of the pre-charge register

  assign step_sel = pre_reg[POS_STEP_SEL];

  // Fields copied as the bytes hold them
  assign cfg_next.term_disable             = term_reg[POS_TERM_DIS];
  assign cfg_next.termination_percent_code =
    term_reg[POS_TERM_LO +: 5];
  assign cfg_next.charge_step_select       = step_sel;
  assign cfg_next.precharge_code           = pre_reg[POS_PRE_LO +: 5];
  assign cfg_next.fast_charge_code         = fast_reg;
  assign cfg_next.regulation_voltage_target = vreg_reg;

  // A 2.5 mA step is two 1.25 mA units, so the range bit is a shift
  // No ceiling beyond the code width
  assign fast_units = step_sel ? {fast_reg, 1'b0}
                               : {1'b0, fast_reg};
  assign pre_units  = step_sel ? {pre_reg[POS_PRE_LO +: 5], 1'b0}
                               : {1'b0, pre_reg[POS_PRE_LO +: 5]};

  // Own flop, so no gate sits before the pin
  assign term_enable_next = ~term_reg[POS_TERM_DIS];

  // Disable resets to zero, so enabled
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      term_enable_reg <= 1'b1;
    end else begin
      term_enable_reg <= term_enable_next;
    end
  end

  // One flop stage so every output comes from a register
  // Units keep the same lag as the struct
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_reg        <= '0;
      fast_units_reg <= 9'h000;
      pre_units_reg  <= 6'h00;
    end else begin
      cfg_reg        <= cfg_next;
      fast_units_reg <= fast_units;
      pre_units_reg  <= pre_units;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  // All pins come straight from flops
  assign REG_RDATA   = rdata_reg;
  assign REG_RVALID  = rvalid_reg;
  assign INT_N       = int_n_reg;
  assign CHARGE_CFG  = cfg_reg;
  assign FAST_UNITS  = fast_units_reg;
  assign PRE_UNITS   = pre_units_reg;
  assign TERM_ENABLE = term_enable_reg;

endmodule : charger_mask_and_charge_regs

// ---- charger_regs_monitor.sv ----
// Port checker of the charger mask and charge register bank
`timescale 1ns/1ps
module charger_regs_monitor (
  input wire logic                        SYS_CLK,      // Clock
  input wire logic                        RSTN,         // Reset, low
  input wire charger_regs_pkg::reg_req_t  REG_REQ,      // Access
  input wire logic [7:0]                  REG_RDATA,    // Read data
  input wire logic                        REG_RVALID,   // Data valid
  input wire logic [7:0]                  CONV_EVENTS,  // Conv pulses
  input wire logic [7:0]                  FAULT_EVENTS, // Fault pulses
  input wire logic                        INT_N,        // Interrupt
  input wire charger_regs_pkg::charge_cfg_t CHARGE_CFG, // Settings
  input wire logic [8:0]                  FAST_UNITS,   // Fast units
  input wire logic [5:0]                  PRE_UNITS,    // Pre units
  input wire logic                        TERM_ENABLE   // Term active
);
  import charger_regs_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] cmask_reg;  // Shadow of converter masks
  logic [7:0] fmask_reg;  // Shadow of fault masks
  wire cm_wr = REG_REQ.wr && REG_REQ.addr == OFF_CONV_MASK; // Mask write
  wire fm_wr = REG_REQ.wr && REG_REQ.addr == OFF_FAULT_MASK;
  wire m_wr = cm_wr || fm_wr;  // Any mask write
  wire [5:0] term_bits = REG_REQ.wdata[5:0];  // Term code and disable
  // Unmasked live event this cycle; only live positions may latch
  wire evt_hit = |(CONV_EVENTS & CONV_LIVE_BITS & ~cmask_reg) ||
                 |(FAULT_EVENTS & FAULT_LIVE_BITS & ~fmask_reg);
  // Shadow masks follow writes so interrupt checks know the gating
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cmask_reg <= RST_CONV_MASK;
      fmask_reg <= RST_FAULT_MASK;
    end else begin
      if (cm_wr) cmask_reg <= REG_REQ.wdata;
      if (fm_wr) fmask_reg <= REG_REQ.wdata;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////
  property p_rd_answer;
    1'b1 |=> REG_RVALID == $past(REG_REQ.rd);
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer not one cycle after request");
  property p_vreg_clamp;
    REG_REQ.wr && REG_REQ.addr == OFF_VREG &&
    REG_REQ.wdata[6:0] > VREG_MAX_CODE
    |-> ##2 CHARGE_CFG.regulation_voltage_target == VREG_MAX_CODE;
  endproperty
  a_vreg_clamp: assert property (p_vreg_clamp)
    else $error("regulation code not saturated");
  property p_vreg_read;
    REG_RVALID && $past(REG_REQ.addr) == OFF_VREG
    |-> REG_RDATA <= {1'b0, VREG_MAX_CODE};
  endproperty
  a_vreg_read: assert property (p_vreg_read)
    else $error("regulation read above ceiling");
  property p_fast_wr;
    REG_REQ.wr && REG_REQ.addr == OFF_FAST_CHG
    |-> ##2 CHARGE_CFG.fast_charge_code == $past(REG_REQ.wdata, 2);
  endproperty
  a_fast_wr: assert property (p_fast_wr)
    else $error("fast charge code not applied");
  property p_term_wr;
    REG_REQ.wr && REG_REQ.addr == OFF_TERM |-> ##2
    {CHARGE_CFG.termination_percent_code, CHARGE_CFG.term_disable}
      == $past(term_bits, 2);
  endproperty
  a_term_wr: assert property (p_term_wr)
    else $error("termination setting not applied");
  property p_fast_units;
    FAST_UNITS == (9'(CHARGE_CFG.fast_charge_code)
                   << CHARGE_CFG.charge_step_select);
  endproperty
  a_fast_units: assert property (p_fast_units)
    else $error("fast units disagree with step");
  property p_pre_units;
    PRE_UNITS == (6'(CHARGE_CFG.precharge_code)
                  << CHARGE_CFG.charge_step_select);
  endproperty
  a_pre_units: assert property (p_pre_units)
    else $error("pre-charge units disagree with step");
  property p_term_en;
    TERM_ENABLE == !CHARGE_CFG.term_disable;
  endproperty
  a_term_en: assert property (p_term_en)
    else $error("termination enable inverted");
  property p_int_hit;
    evt_hit && !m_wr |-> ##2 !INT_N;
  endproperty
  a_int_hit: assert property (p_int_hit)
    else $error("unmasked event gave no interrupt");
  property p_int_fall;
    $fell(INT_N) |-> $past(evt_hit, 2) || $past(m_wr, 2);
  endproperty
  a_int_fall: assert property (p_int_fall)
    else $error("interrupt without unmasked cause");
endmodule : charger_regs_monitor

bind charger_mask_and_charge_regs charger_regs_monitor i_mon (
  .SYS_CLK, .RSTN, .REG_REQ, .REG_RDATA, .REG_RVALID, .CONV_EVENTS,
  .FAULT_EVENTS, .INT_N, .CHARGE_CFG, .FAST_UNITS, .PRE_UNITS, .TERM_ENABLE);

// ---- host_request_driver.sv ----
// Host model issuing single-byte register requests to the bank
`timescale 1ns/1ps
module host_request_driver (
  input  wire logic                  clk,    // System clock
  input  wire logic [7:0]            rdata,  // Read data
  input  wire logic                  rvalid, // Read answer
  output charger_regs_pkg::reg_req_t req     // Request
);
  import charger_regs_pkg::*;
  initial req = '0;
  // One write, none for a termination byte with a zero code; released lines show the inverse so nothing stale is used
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    if (a == OFF_TERM && d[5:1] == 5'h00) return;
    @(posedge clk);
    #2;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clk);
    #2;
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask : put
  // One read; answer is taken in the cycle after the request edge
  task automatic get(input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
    @(posedge clk);
    #2;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk);
    #2;
    req.rd = 1'b0;
    req.addr = ~a;
    ok = rvalid;
    d = rdata;
  endtask : get
endmodule : host_request_driver

// ---- test_charger_mask_and_charge_regs.sv ----
// Self-checking test of the charger mask and charge register bank
`timescale 1ns/1ps
module test_charger_mask_and_charge_regs;
  import charger_regs_pkg::*;
  logic clk = 1'b0;           // 40 MHz clock
  logic rstn = 1'b0;          // Reset, active low
  logic [7:0] conv_ev = '0;   // Converter event pulses
  logic [7:0] fault_ev = '0;  // Fault event pulses
  reg_req_t req;              // Request from host model
  logic [7:0] rdata;          // Read data
  logic rvalid;               // Read answer
  logic int_n;                // Interrupt
  charge_cfg_t cfg;           // Settings
  logic [8:0] fast_u;         // Fast units
  logic [5:0] pre_u;          // Pre units
  logic term_en;              // Termination active
  int failures = 0;           // Mismatches
  int check_count = 0;        // Comparisons
  localparam logic [7:0] RA [7] = '{8'h09, 8'h0a, 8'h12, 8'h13, 8'h14,
                                    8'h15, 8'h30};
  localparam logic [7:0] RV [7] = '{8'h71, 8'h00, 8'h3c, 8'h08, 8'h02,
                                    8'h14, 8'h00};
  localparam logic [7:0] VW [6] = '{8'h7f, 8'he5, 8'h65, 8'h64, 8'h63, 8'h00};
  localparam logic [7:0] VE [6] = '{8'h64, 8'h64, 8'h64, 8'h64, 8'h63, 8'h00};
  always #12.5 clk = ~clk;
  charger_mask_and_charge_regs i_charger_mask_and_charge_regs (
    .SYS_CLK(clk), .RSTN(rstn), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .CONV_EVENTS(conv_ev), .FAULT_EVENTS(fault_ev),
    .INT_N(int_n), .CHARGE_CFG(cfg), .FAST_UNITS(fast_u),
    .PRE_UNITS(pre_u), .TERM_ENABLE(term_en));
  host_request_driver i_host_request_driver (
    .clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #2;
  endtask : tick
  // Read a register; valid flag and data are compared together
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i_host_request_driver.get(a, d, ok);
    chk({ok, d}, {1'b1, e});
  endtask : rd_chk
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    i_host_request_driver.put(a, d);
  endtask : put
  // One-cycle event pulse, then the cycle in which the interrupt moves
  task automatic pulse(input logic [7:0] c, input logic [7:0] f);
    tick();
    conv_ev = c;
    fault_ev = f;
    tick();
    conv_ev = 8'h00;
    fault_ev = 8'h00;
    tick();
  endtask : pulse
  task automatic wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(25 * 5000);
    failures++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    #2;
    rstn = 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(RA[i], RV[i]);
    chk(cfg, {1'b0, 5'h0a, 1'b0, 5'h02, 8'h08, 7'h3c});
    chk({fast_u, pre_u, term_en}, {9'h008, 6'h02, 1'b1});
    // Every fault source alone reaches the interrupt, read clears it
    for (int b = 0; b < 7; b++) begin
      pulse(8'h00, 8'h01 << b);
      chk(int_n, 1'b0);
      rd_chk(OFF_FAULT_FLAG, 8'h01 << b);
      tick();
      chk(int_n, 1'b1);
    end
    pulse(8'h7f, 8'h80);
    chk(int_n, 1'b1);
    rd_chk(OFF_CONV_FLAG, 8'h71);
    rd_chk(OFF_FAULT_FLAG, 8'h00);
    pulse(8'h80, 8'h00);
    chk(int_n, 1'b0);
    rd_chk(OFF_CONV_FLAG, 8'h80);
    put(OFF_FAULT_MASK, 8'h40);
    pulse(8'h00, 8'h40);
    chk(int_n, 1'b1);
    put(OFF_FAULT_MASK, 8'h00);
    tick();
    chk(int_n, 1'b0);
    rd_chk(OFF_FAULT_FLAG, 8'h40);
    tick();
    chk(int_n, 1'b1);
    // Mask storage, including reserved positions; flags ignore writes
    put(OFF_CONV_MASK, 8'h8e);
    rd_chk(OFF_CONV_MASK, 8'h8e);
    put(OFF_FAULT_MASK, 8'hff);
    rd_chk(OFF_FAULT_MASK, 8'hff);
    put(OFF_CONV_FLAG, 8'hff);
    rd_chk(OFF_CONV_FLAG, 8'h00);
    for (int i = 0; i < 6; i++) begin
      put(OFF_VREG, VW[i]);
      rd_chk(OFF_VREG, VE[i]);
      chk(cfg.regulation_voltage_target, VE[i][6:0]);
    end
    put(OFF_FAST_CHG, 8'hc8);
    put(OFF_PRECHG, 8'hff);
    tick();
    chk({fast_u, pre_u}, {9'h190, 6'h3e});
    rd_chk(OFF_PRECHG, 8'hff);
    put(OFF_PRECHG, 8'h1f);
    tick();
    chk({fast_u, pre_u}, {9'h0c8, 6'h1f});
    put(OFF_TERM, 8'h3f);
    tick();
    chk({term_en, cfg.termination_percent_code}, {1'b0, 5'h1f});
    put(OFF_TERM, 8'h02);
    put(OFF_TERM, 8'h01);
    tick();
    chk({term_en, cfg.termination_percent_code}, {1'b1, 5'h01});
    // Second reset in mid-run restores defaults
    rstn = 1'b0;
    tick();
    rstn = 1'b1;
    rd_chk(OFF_VREG, 8'h3c);
    rd_chk(OFF_CONV_MASK, 8'h71);
    wrap_up();
  end
endmodule : test_charger_mask_and_charge_regs
